// >>> include/pattern_output_pkg.sv
package pattern_output_pkg;
   // register byte offsets on the bus
   localparam logic [7:0] OFF_NEXT_ENABLE_LOW = 8'h00;
   localparam logic [7:0] OFF_NEXT_ENABLE_HIGH = 8'h04;
   localparam logic [7:0] OFF_TRIGGER_SELECT = 8'h08;
   localparam logic [7:0] OFF_NEXT_DATA_LOW = 8'h0C;
   localparam logic [7:0] OFF_NEXT_DATA_HIGH = 8'h10;
   localparam logic [7:0] OFF_PORT_B_DATA = 8'h14;
   // reset values
   localparam logic [7:0] RST_NEXT_ENABLE = 8'h00;
   localparam logic [7:0] RST_TRIGGER_SELECT = 8'hFF;
   localparam logic [7:0] RST_NEXT_DATA = 8'h00;
   localparam logic [15:0] RST_PORT_B_DATA = 16'h0000;
   // layout
   localparam int GROUP_COUNT = 4;
   localparam int GROUP_WIDTH = 4;
   localparam int SEL_WIDTH = 2;
   localparam int CHANNEL_COUNT = 4;
   localparam int PORT_WIDTH = 16;
endpackage

// >>> logic/group_trigger_select.sv
`timescale 1ns/1ns
// picks one channel's compare-match A pulse for one output group
module group_trigger_select
   import pattern_output_pkg::*;
(
   // selection
   input wire logic [SEL_WIDTH-1:0] channelSel,
   // compare-match pulses from the timer unit
   input wire logic [CHANNEL_COUNT-1:0] compareMatchA,
   // chosen trigger
   output logic groupTrigger
);
   assign groupTrigger = compareMatchA[channelSel]; // [RULE14]
endmodule // group_trigger_select

// >>> logic/pattern_output_enable_trigger.sv
`timescale 1ns/1ns
// Functional notes
// [RULE1] on selected match, enabled low next-data bits load port bits 7..0
// [RULE2] on selected match, enabled high next-data bits load port bits 15..8
// [RULE3] disabled bits never transfer; their port value stays as it was
// [RULE4] low enable register, 8 bits read/write, bit n gates bit n
// [RULE5] high enable register, 8 bits read/write, bit k gates bit k+8
// [RULE6] low enables reset to zero and survive standby
// [RULE7] high enables reset to zero and survive standby
// [RULE8] trigger select resets to all ones, channel 3, survives standby
// [RULE9] select bits 7..6 choose channel for group 3, outputs 15..12
// [RULE10] select bits 5..4 choose channel for group 2, outputs 11..8
// [RULE11] select bits 3..2 choose channel for group 1, outputs 7..4
// [RULE12] select bits 1..0 choose channel for group 0, outputs 3..0
// [RULE13] software writes cannot change port bits enabled for pattern output
// [RULE14] ordinary mode triggers on compare match A of the chosen channel
// [RULE15] next-data resets to zero; upper nibble odd group, lower even group
// [RULE16] all enabled bits of a group update in the pulse's sampled cycle
module pattern_output_enable_trigger
   import pattern_output_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // timer unit compare-match A pulses, one per channel
   input wire logic [CHANNEL_COUNT-1:0] compareMatchA,
   // standby request; registers hold their contents regardless
   input wire logic standby,
   // pattern pins
   output logic [PORT_WIDTH-1:0] pattern_pins,
   output logic [PORT_WIDTH-1:0] patternEnable
);
   logic resetMeta_q;
   logic resetSync_q;
   logic [7:0] nextEnableLow_q;
   logic [7:0] nextEnableHigh_q;
   logic [7:0] triggerSelect_q;
   logic [7:0] nextDataLow_q;
   logic [7:0] nextDataHigh_q;
   logic [PORT_WIDTH-1:0] portData_q;
   logic [PORT_WIDTH-1:0] portData_d;
   logic [31:0] prdata_q;
   logic [31:0] readData;
   logic [GROUP_COUNT-1:0] groupTrigger;
   logic [PORT_WIDTH-1:0] enableAll;
   logic [PORT_WIDTH-1:0] nextAll;
   logic writeAccess;
   logic readSetup;
   logic addrHit;

   // reset released through two flops
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         resetMeta_q <= 1'b0;
         resetSync_q <= 1'b0;
      end else begin
         resetMeta_q <= 1'b1;
         resetSync_q <= resetMeta_q;
      end
   end

   // zero-wait slave: the access phase always completes in one cycle
   assign pready = 1'b1;
   assign writeAccess = psel && penable && pwrite;
   assign readSetup = psel && !penable && !pwrite;
   assign addrHit = (paddr == OFF_NEXT_ENABLE_LOW) || (paddr == OFF_NEXT_ENABLE_HIGH)
      || (paddr == OFF_TRIGGER_SELECT) || (paddr == OFF_NEXT_DATA_LOW)
      || (paddr == OFF_NEXT_DATA_HIGH) || (paddr == OFF_PORT_B_DATA);
   assign pslverr = psel && penable && !addrHit;

   // standby is deliberately not a term here: contents are kept through it
   always_ff @(posedge clk or negedge resetSync_q) begin
      if (!resetSync_q) begin
         nextEnableLow_q <= RST_NEXT_ENABLE; // [RULE6]
         nextEnableHigh_q <= RST_NEXT_ENABLE; // [RULE7]
         triggerSelect_q <= RST_TRIGGER_SELECT; // [RULE8]
      end else if (writeAccess) begin
         if (paddr == OFF_NEXT_ENABLE_LOW) begin
            nextEnableLow_q <= pwdata[7:0]; // [RULE4]
         end
         if (paddr == OFF_NEXT_ENABLE_HIGH) begin
            nextEnableHigh_q <= pwdata[7:0]; // [RULE5]
         end
         if (paddr == OFF_TRIGGER_SELECT) begin
            triggerSelect_q <= pwdata[7:0];
         end
      end
   end

   always_ff @(posedge clk or negedge resetSync_q) begin
      if (!resetSync_q) begin
         nextDataLow_q <= RST_NEXT_DATA; // [RULE15]
         nextDataHigh_q <= RST_NEXT_DATA; // [RULE15]
      end else if (writeAccess) begin
         if (paddr == OFF_NEXT_DATA_LOW) begin
            nextDataLow_q <= pwdata[7:0];
         end
         if (paddr == OFF_NEXT_DATA_HIGH) begin
            nextDataHigh_q <= pwdata[7:0];
         end
      end
   end

   assign enableAll = {nextEnableHigh_q, nextEnableLow_q};
   assign nextAll = {nextDataHigh_q, nextDataLow_q};

   // per group: two select bits pick a channel (bits 1..0 group 0 ... 7..6 group 3)
   genvar g;
   generate
      for (g = 0; g < GROUP_COUNT; g++) begin : groupGen
         group_trigger_select selectInst (
            .channelSel(triggerSelect_q[g*SEL_WIDTH +: SEL_WIDTH]), // [RULE9] [RULE10] [RULE11] [RULE12]
            .compareMatchA(compareMatchA),
            .groupTrigger(groupTrigger[g])
         );
      end
   endgenerate

   // software writes touch only disabled bits; a transfer on the same edge wins
   always_comb begin
      portData_d = portData_q;
      if (writeAccess && (paddr == OFF_PORT_B_DATA)) begin
         portData_d = (portData_q & enableAll) | (pwdata[15:0] & ~enableAll); // [RULE13]
      end
      for (int i = 0; i < PORT_WIDTH; i++) begin
         if (groupTrigger[i / GROUP_WIDTH] && enableAll[i]) begin // [RULE3] [RULE16]
            portData_d[i] = nextAll[i]; // [RULE1] [RULE2]
         end
      end
   end

   always_ff @(posedge clk or negedge resetSync_q) begin
      if (!resetSync_q) begin
         portData_q <= RST_PORT_B_DATA;
      end else begin
         portData_q <= portData_d;
      end
   end

   assign pattern_pins = portData_q;
   assign patternEnable = enableAll;

   always_comb begin
      readData = 32'h0000_0000;
      unique case (paddr)
         OFF_NEXT_ENABLE_LOW: readData[7:0] = nextEnableLow_q;
         OFF_NEXT_ENABLE_HIGH: readData[7:0] = nextEnableHigh_q;
         OFF_TRIGGER_SELECT: readData[7:0] = triggerSelect_q;
         OFF_NEXT_DATA_LOW: readData[7:0] = nextDataLow_q;
         OFF_NEXT_DATA_HIGH: readData[7:0] = nextDataHigh_q;
         OFF_PORT_B_DATA: readData[15:0] = portData_q;
         default: readData = 32'h0000_0000;
      endcase
   end

   // read data registered in the setup cycle, valid through the access phase
   always_ff @(posedge clk or negedge resetSync_q) begin
      if (!resetSync_q) begin
         prdata_q <= 32'h0000_0000;
      end else if (readSetup) begin
         prdata_q <= readData;
      end
   end

   assign prdata = prdata_q;

endmodule // pattern_output_enable_trigger

// >>> tb/timer_unit_model.sv
`timescale 1ns/1ns
// timer side: one-cycle match pulses on request, quiet otherwise
module timer_unit_model (
   // clock and pulses
   input wire logic clk,
   output logic [3:0] compareMatchA
);
   initial compareMatchA = 4'h0;
   task automatic fire(input logic [3:0] ch);
      @(posedge clk);
      compareMatchA <= ch;
      @(posedge clk);
      compareMatchA <= 4'h0;
   endtask
endmodule // timer_unit_model

// >>> tb/pattern_output_enable_trigger_sva.sv
`timescale 1ns/1ns
module pattern_output_enable_trigger_sva (
   // top ports
   input wire logic clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [3:0] compareMatchA,
   input wire logic standby,
   input wire logic [15:0] pattern_pins,
   input wire logic [15:0] patternEnable
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic wr;
   logic [15:0] nd_q;
   logic [7:0] sel_q;
   assign wr = psel && penable && pwrite;
   // shadows of state that never reaches the ports
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         nd_q <= 16'h0000;
         sel_q <= 8'hFF;
      end else if (wr) begin
         case (paddr)
            8'h08: sel_q <= pwdata[7:0];
            8'h0C: nd_q[7:0] <= pwdata[7:0];
            8'h10: nd_q[15:8] <= pwdata[7:0];
            default: ;
         endcase
      end
   end
   sequence enWr(logic [7:0] a);
      wr && paddr == a;
   endsequence
   sequence rdSetup(logic [7:0] a);
      psel && !penable && !pwrite && paddr == a;
   endsequence
   a_low_enable_write: assert property (
      enWr(8'h00) |=> patternEnable[7:0] == $past(pwdata[7:0])) else $error("low enable");
   a_high_enable_write: assert property (
      enWr(8'h04) |=> patternEnable[15:8] == $past(pwdata[7:0])) else $error("high enable");
   a_enable_readback: assert property (
      rdSetup(8'h04) |=> prdata[7:0] == $past(patternEnable[15:8])) else $error("readback");
   a_enable_hold: assert property (
      !(wr && paddr inside {8'h00, 8'h04}) |=> $stable(patternEnable)) else $error("hold");
   a_disabled_hold: assert property (
      !(wr && paddr == 8'h14) |=>
      ((pattern_pins ^ $past(pattern_pins)) & ~$past(patternEnable)) == 16'h0000)
      else $error("disabled bit moved");
   a_enabled_readonly: assert property (
      compareMatchA == 4'h0 |=>
      ((pattern_pins ^ $past(pattern_pins)) & $past(patternEnable)) == 16'h0000)
      else $error("enabled bit moved");
   a_error_response: assert property (
      psel && penable |-> pready && pslverr == (paddr > 8'h14 || paddr[1:0] != 2'b00))
      else $error("response");
   for (genvar g = 0; g < 4; g++) begin : grp
      a_group_load: assert property (
         compareMatchA[sel_q[2*g+:2]] |=>
         (pattern_pins[4*g+:4] & $past(patternEnable[4*g+:4]))
         == ($past(nd_q[4*g+:4]) & $past(patternEnable[4*g+:4]))) else $error("load");
   end
endmodule // pattern_output_enable_trigger_sva
bind pattern_output_enable_trigger pattern_output_enable_trigger_sva
   pattern_output_enable_trigger_sva_inst (.clk, .reset_n, .psel, .penable, .pwrite, .paddr,
   .pwdata, .prdata, .pready, .pslverr, .compareMatchA, .standby, .pattern_pins, .patternEnable);

// >>> tb/pattern_output_enable_trigger_tb.sv
`timescale 1ns/1ns
module pattern_output_enable_trigger_tb;
   import pattern_output_pkg::*;
   logic clk = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic standby = 1'b0, pready, pslverr, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] compareMatchA;
   logic [15:0] pattern_pins, patternEnable, exp;
   int n_fail = 0, cmp_count = 0;
   always #25 clk = ~clk;
   pattern_output_enable_trigger pattern_output_enable_trigger_inst (.clk, .reset_n, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .compareMatchA,
      .standby, .pattern_pins, .patternEnable);
   timer_unit_model timer_unit_model_inst (.clk, .compareMatchA);
   task automatic test_done();
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      cmp_count++;
      if (got !== want) begin
         n_fail++;
         $display("unexpected at %0t got %h want %h", $time, got, want);
      end
   endtask
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         err = pslverr;
      end while (pready !== 1'b1 && n < 20);
      // only a wait that ended without an answer counts as a timeout
      if (pready !== 1'b1) begin
         chk(32'(pready), 32'h1);
         test_done();
      end
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] want);
      xfer(a, 1'b0, 32'h0);
      chk(rd, want);
   endtask
   initial begin
      repeat (6) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge clk);
      chk(32'(patternEnable), 32'h0);
      for (int i = 0; i < 6; i++) begin
         rdchk(8'(4 * i), i == 2 ? 32'hFF : 32'h0);
      end
      $display("test reset done");
      xfer(OFF_NEXT_ENABLE_LOW, 1'b1, 32'hA5);
      xfer(OFF_NEXT_ENABLE_HIGH, 1'b1, 32'h5A);
      xfer(OFF_TRIGGER_SELECT, 1'b1, 32'hE4);
      xfer(OFF_NEXT_DATA_LOW, 1'b1, 32'hFF);
      xfer(OFF_NEXT_DATA_HIGH, 1'b1, 32'hFF);
      // contents written before standby must still be there once it is entered
      standby <= 1'b1;
      rdchk(OFF_NEXT_ENABLE_LOW, 32'hA5);
      rdchk(OFF_NEXT_ENABLE_HIGH, 32'h5A);
      rdchk(OFF_TRIGGER_SELECT, 32'hE4);
      chk(32'(patternEnable), 32'h5AA5);
      xfer(8'h18, 1'b1, 32'hFF);
      chk(32'(err), 32'h1);
      rdchk(8'h18, 32'h0);
      $display("test registers done");
      exp = 16'h0000;
      for (int c = 0; c < 4; c++) begin
         timer_unit_model_inst.fire(4'(1 << c));
         #1;
         for (int g = 0; g < 4; g++) begin
            if (((8'hE4 >> (2 * g)) & 8'h03) == 8'(c)) exp = exp | (16'h5AA5 & (16'hF << (4 * g)));
         end
         chk(32'(pattern_pins), 32'(exp));
      end
      $display("test transfer done");
      // enabled bits must ignore the write, disabled ones take it
      xfer(OFF_PORT_B_DATA, 1'b1, 32'h0F0F);
      rdchk(OFF_PORT_B_DATA, 32'h5FAF);
      xfer(OFF_NEXT_DATA_LOW, 1'b1, 32'h0);
      xfer(OFF_NEXT_DATA_HIGH, 1'b1, 32'h0);
      timer_unit_model_inst.fire(4'hF);
      #1;
      chk(32'(pattern_pins), 32'h050A);
      $display("test port done");
      test_done();
   end
endmodule // pattern_output_enable_trigger_tb
